// File: ufs_pkg.sv
// Constants for the USB host functional-state controller
package ufs_pkg;
  // ****************************************
  // Functional state codes
  // ****************************************
  localparam logic [1:0] ST_BUS_RESET = 2'h0;
  localparam logic [1:0] ST_RESUME    = 2'h1;
  localparam logic [1:0] ST_OPER      = 2'h2;
  localparam logic [1:0] ST_SUSPEND   = 2'h3;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_REVISION = 8'h00;
  localparam logic [7:0] OFS_CONTROL  = 8'h04;
  localparam logic [7:0] OFS_COMMAND  = 8'h08;
  localparam logic [7:0] OFS_COMM_PTR = 8'h18;
  localparam logic [7:0] OFS_RH_STAT  = 8'h50;
  localparam logic [7:0] OFS_MEM_LAST = 8'h4c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_LIST_LO  = 2;
  localparam int CTL_LIST_HI  = 5;
  localparam int CTL_STATE_LO = 6;
  localparam int CTL_STATE_HI = 7;
  localparam int CTL_SOF_IE   = 8;
  localparam int CMD_SW_RESET = 0;
  localparam int PTR_LOW_BITS = 8;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [31:0] CONTROL_RST  = 32'h0000_0000;
  localparam logic [31:0] CONTROL_MASK = 32'h0000_01ff;
  localparam logic [31:0] COMM_PTR_RST = 32'h0000_0000;
  localparam logic [31:0] RH_STAT_RST  = 32'h0000_0000;
  localparam logic [31:0] REVISION_ID  = 32'h0000_0001; // Arbitrary value

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS   = 25000;
  localparam int FRAME_TIME_US   = 1000;
  localparam int FRAME_TIME_PS   = FRAME_TIME_US * 1000000;
  localparam int FRAME_CYCLES    = FRAME_TIME_PS / CLK_PERIOD_PS;
  localparam int SHORT_SUSP_US   = 1000;
  localparam int SHORT_SUSP_CYCLES = SHORT_SUSP_US * 1000 / (CLK_PERIOD_PS / 1000) / 1000 * 1000;
  localparam int CNT_W           = 20;
  localparam int MEM_AW          = 5;
endpackage

// File: ufs_mem.sv
// Word memory holding the general operational registers
`timescale 1ns/100ps
module ufs_mem
  import ufs_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Write port
  input  wire logic              we,
  input  wire logic [MEM_AW-1:0] waddr,
  input  wire logic [31:0]       wdata,
  // Read port
  input  wire logic              re,
  input  wire logic [MEM_AW-1:0] raddr,
  output logic      [31:0]       rdata
);
  logic [31:0] words [0:(1<<MEM_AW)-1];

  // ****************************************
  // Storage and registered read
  // ****************************************
  always_ff @(posedge clk) begin
    if (we) begin
      words[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (re) begin
      rdata <= words[raddr];
    end
  end
endmodule

// File: ufs_ctrl.sv
// Functional-state controller of the USB host controller
`timescale 1ns/100ps
// Contract
// R1 - Bus reset keeps operational registers, clears root-hub registers, uses state field.
// R2 - Bus reset state resets the root hub and its downstream ports.
// R3 - Only ownership-change may interrupt during bus reset.
// R4 - Software holds bus reset at least the USB reset time.
// R5 - Operational state emits frame starts and runs enabled lists.
// R6 - First frame start within one millisecond, flagged if its interrupt enabled.
// R7 - Resume-detected never raised in operational state.
// R8 - Suspend: no frame starts, no lists, registers kept.
// R9 - Suspend watches for resume; on detect, state becomes resume, interrupt raised.
// R10 - In suspend software writes state only as bus reset or resume.
// R11 - Software keeps suspend at least five milliseconds normally.
// R12 - Short suspend after software reset may return straight to operational.
// R13 - Suspend allows only resume-detected and ownership-change interrupts.
// R14 - Resume drives resume signalling, no tokens, no lists, registers kept.
// R15 - Software holds resume at least the USB resume time.
// R16 - Only ownership-change may interrupt during resume.
// R17 - Software uses whole 32-bit word accesses only.
// R18 - Software preserves reserved fields and never assumes zero.
// R19 - Set or clear writes carry zeros in reserved fields.
// R20 - Pointer register gives the shared communication area base.
// R21 - Driver start-up avoids bus reset where possible.
// R22 - State codes reset 00, resume 01, operational 10, suspend 11; reset enters bus reset.
module ufs_ctrl
  import ufs_pkg::*;
#(
  parameter int FRAME_CNT = FRAME_CYCLES,
  parameter int SHORT_CNT = SHORT_SUSP_CYCLES
)(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  // Register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // Bus pin
  input  wire logic        RESUME_IN,
  output logic             RESUME_DRIVE,
  // Raw interrupt sources
  input  wire logic        OWNER_RAW,
  input  wire logic [3:0]  OTHER_RAW,
  // Gated interrupt events
  output logic             OWNER_IRQ,
  output logic             SOF_IRQ,
  output logic             RESUME_IRQ,
  output logic      [3:0]  OTHER_IRQ,
  // Controller status and control
  output logic             SOF_TOKEN,
  output logic      [3:0]  LIST_EN,
  output logic             RH_RESET,
  output logic      [1:0]  FUNC_STATE,
  output logic      [31:0] COMM_BASE
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [31:0]       control;
  logic [31:0]       comm_ptr;
  logic [31:0]       rh_status;
  logic [1:0]        state;
  logic [1:0]        wr_state;
  logic              rs1;
  logic              rs2;
  logic              rs3;
  logic              resume_seen;
  logic              resume_det;
  logic              ctl_wr;
  logic              cmd_wr;
  logic              sw_reset;
  logic              write_ok;
  logic              short_flag;
  logic              short_ok;
  logic [CNT_W-1:0]  frame_cnt;
  logic [CNT_W-1:0]  susp_cnt;
  logic              frame_tick;
  logic              mem_we;
  logic              mem_re;
  logic              rd_from_mem;
  logic [31:0]       mem_q;
  logic [31:0]       reg_q;
  logic [31:0]       next_reg_q;

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic is_mem_addr(input logic [7:0] a);
    return (a > OFS_COMMAND) && (a <= OFS_MEM_LAST) && (a != OFS_COMM_PTR)
           && (a[1:0] == 2'h0);
  endfunction

  assign ctl_wr   = WR && (ADDR == OFS_CONTROL);
  assign cmd_wr   = WR && (ADDR == OFS_COMMAND);
  assign sw_reset = cmd_wr && WDATA[CMD_SW_RESET];
  assign mem_we   = WR && is_mem_addr(ADDR);
  assign mem_re   = RD && is_mem_addr(ADDR);
  assign wr_state = WDATA[CTL_STATE_HI:CTL_STATE_LO];

  // ****************************************
  // Resume pin synchroniser
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rs1 <= 1'b0;
      rs2 <= 1'b0;
      rs3 <= 1'b0;
    end else begin
      rs1 <= RESUME_IN;
      rs2 <= rs1;
      rs3 <= rs2;
    end
  end

  assign resume_seen = rs2 && rs3;
  assign resume_det  = (state == ST_SUSPEND) && resume_seen; // [R9]

  // ****************************************
  // Suspend write guard
  // ****************************************
  assign short_ok = short_flag && (susp_cnt < CNT_W'(SHORT_CNT)); // [R12]
  always_comb begin
    write_ok = 1'b1;
    if (state == ST_SUSPEND) begin
      write_ok = (wr_state == ST_BUS_RESET) || (wr_state == ST_RESUME)
                 || ((wr_state == ST_OPER) && short_ok); // [R12]
    end
  end

  // ****************************************
  // Functional state
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state <= ST_BUS_RESET; // [R22]
    end else if (resume_det) begin
      state <= ST_RESUME; // [R9]
    end else if (sw_reset) begin
      state <= ST_SUSPEND;
    end else if (ctl_wr && write_ok) begin
      state <= wr_state;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      control <= CONTROL_RST;
    end else if (sw_reset) begin
      control <= CONTROL_RST;
    end else if (ctl_wr) begin
      control <= WDATA & CONTROL_MASK;
    end
  end

  // ****************************************
  // Short suspend tracking
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      short_flag <= 1'b0;
    end else if (sw_reset) begin
      short_flag <= (state != ST_SUSPEND); // [R12]
    end else if (state != ST_SUSPEND) begin
      short_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      susp_cnt <= '0;
    end else if (sw_reset || (state != ST_SUSPEND)) begin
      susp_cnt <= '0;
    end else if (susp_cnt != '1) begin
      susp_cnt <= susp_cnt + CNT_W'(1);
    end
  end

  // ****************************************
  // Frame timer
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      frame_cnt <= '0;
    end else if (state != ST_OPER) begin
      frame_cnt <= CNT_W'(1);
    end else if (frame_tick) begin
      frame_cnt <= '0;
    end else begin
      frame_cnt <= frame_cnt + CNT_W'(1);
    end
  end

  assign frame_tick = (state == ST_OPER) && (frame_cnt == CNT_W'(FRAME_CNT - 1)); // [R6]

  // ****************************************
  // Bus-side outputs
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      SOF_TOKEN    <= 1'b0;
      LIST_EN      <= 4'h0;
      RESUME_DRIVE <= 1'b0;
      RH_RESET     <= 1'b1;
    end else begin
      SOF_TOKEN    <= frame_tick; // [R5] [R8]
      LIST_EN      <= (state == ST_OPER) ? control[CTL_LIST_HI:CTL_LIST_LO] : 4'h0; // [R5]
      RESUME_DRIVE <= (state == ST_RESUME); // [R14]
      RH_RESET     <= (state == ST_BUS_RESET); // [R2]
    end
  end

  assign FUNC_STATE = state;

  // ****************************************
  // Interrupt gating by state
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      OWNER_IRQ  <= 1'b0;
      SOF_IRQ    <= 1'b0;
      RESUME_IRQ <= 1'b0;
      OTHER_IRQ  <= 4'h0;
    end else begin
      OWNER_IRQ  <= OWNER_RAW; // [R3] [R16]
      SOF_IRQ    <= frame_tick && control[CTL_SOF_IE]; // [R6]
      RESUME_IRQ <= resume_det; // [R7] [R13]
      OTHER_IRQ  <= (state == ST_OPER) ? OTHER_RAW : 4'h0; // [R3] [R13] [R16]
    end
  end

  // ****************************************
  // Pointer and root-hub registers
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      comm_ptr <= COMM_PTR_RST;
    end else if (WR && (ADDR == OFS_COMM_PTR)) begin
      comm_ptr <= {WDATA[31:PTR_LOW_BITS], PTR_LOW_BITS'(0)}; // [R20]
    end
  end

  assign COMM_BASE = comm_ptr;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rh_status <= RH_STAT_RST;
    end else if (state == ST_BUS_RESET) begin
      rh_status <= RH_STAT_RST; // [R1]
    end else if (WR && (ADDR == OFS_RH_STAT)) begin
      rh_status <= WDATA;
    end
  end

  // ****************************************
  // General register storage
  // ****************************************
  ufs_mem u_mem (
    .clk   (CLOCK),
    .we    (mem_we),
    .waddr (ADDR[MEM_AW+1:2]),
    .wdata (WDATA),
    .re    (mem_re),
    .raddr (ADDR[MEM_AW+1:2]),
    .rdata (mem_q)
  );

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    next_reg_q = 32'h0000_0000;
    unique case (ADDR)
      OFS_REVISION: next_reg_q = REVISION_ID;
      OFS_CONTROL:  next_reg_q = {control[31:CTL_STATE_HI+1], state,
                                  control[CTL_STATE_LO-1:0]}; // [R1]
      OFS_COMM_PTR: next_reg_q = comm_ptr;
      OFS_RH_STAT:  next_reg_q = rh_status;
      default:      next_reg_q = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      reg_q       <= 32'h0000_0000;
      rd_from_mem <= 1'b0;
    end else begin
      reg_q       <= RD ? next_reg_q : 32'h0000_0000;
      rd_from_mem <= mem_re;
    end
  end

  assign RDATA = rd_from_mem ? mem_q : reg_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  logic [CNT_W-1:0] wait_sof;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      wait_sof <= '0;
    end else if ((state != ST_OPER) || SOF_TOKEN) begin
      wait_sof <= '0;
    end else begin
      wait_sof <= wait_sof + CNT_W'(1);
    end
  end

  sequence seq_resume_seen;
    (state == ST_SUSPEND) && resume_seen;
  endsequence

  sequence seq_resume_taken;
    (FUNC_STATE == ST_RESUME) && RESUME_IRQ;
  endsequence

  chk_reset_root_hub: assert property ((state == ST_BUS_RESET) |=> RH_RESET) // [R2]
    else $error("root hub not reset in bus reset");
  chk_reset_irq_only: assert property ((state == ST_BUS_RESET) |=>
      (!SOF_IRQ && !RESUME_IRQ && (OTHER_IRQ == 4'h0))) // [R3]
    else $error("interrupt other than ownership in bus reset");
  chk_reset_rh_clear: assert property ((state == ST_BUS_RESET) |=> (rh_status == RH_STAT_RST)) // [R1]
    else $error("root hub register kept in bus reset");
  chk_oper_lists: assert property ((state == ST_OPER) |=>
      (LIST_EN == $past(control[CTL_LIST_HI:CTL_LIST_LO]))) // [R5]
    else $error("list enables not followed in operational");
  chk_first_sof: assert property ((state == ST_OPER) |-> (wait_sof < CNT_W'(FRAME_CNT))) // [R6]
    else $error("no frame start within one frame");
  chk_frame_period: assert property ((SOF_TOKEN && (state == ST_OPER)) |-> // [R5]
      (wait_sof == CNT_W'(FRAME_CNT - 1)))
    else $error("frame start period wrong");
  chk_oper_no_resume: assert property ((state == ST_OPER) |=> !RESUME_IRQ) // [R7]
    else $error("resume detected raised in operational");
  chk_suspend_quiet: assert property ((state == ST_SUSPEND) |=>
      (!SOF_TOKEN && (LIST_EN == 4'h0) && !SOF_IRQ && (OTHER_IRQ == 4'h0))) // [R8] [R13]
    else $error("activity in suspend");
  chk_resume_detect: assert property (seq_resume_seen |=> seq_resume_taken) // [R9]
    else $error("resume not taken from suspend");
  chk_resume_quiet: assert property ((state == ST_RESUME) |=>
      (RESUME_DRIVE && !SOF_TOKEN && !RESUME_IRQ && (OTHER_IRQ == 4'h0))) // [R14] [R16]
    else $error("resume state misbehaves");
  chk_suspend_guard: assert property (((state == ST_SUSPEND) && ctl_wr && !sw_reset
      && !resume_seen && (wr_state == ST_OPER) && !short_ok) |=> (state == ST_SUSPEND)) // [R12]
    else $error("illegal exit from suspend taken");
  chk_comm_pointer: assert property ((WR && (ADDR == OFS_COMM_PTR)) |=>
      (COMM_BASE[31:PTR_LOW_BITS] == $past(WDATA[31:PTR_LOW_BITS]))) // [R20]
    else $error("communication area base not loaded");
endmodule

// File: ufs_dev_model.sv
// Model of a USB device behind the root hub ports
`timescale 1ns/100ps
module ufs_dev_model #(
  parameter int SIG_LEN = 12
)(
  // Clock
  input  wire logic clock,
  // Host side
  input  wire logic rh_reset,
  input  wire logic wake,
  // Bus pin
  output logic      resume_in
);
  int left;

  // Resume signalling on request, silent while its port is reset
  always_ff @(posedge clock) begin
    if (rh_reset) begin
      left <= 0;
    end else if (wake) begin
      left <= SIG_LEN;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end

  // Line pulled low when idle
  assign resume_in = (left > 0);
endmodule

// File: usb_host_functional_state_ctrl_tb.sv
// Testbench for the USB host functional-state controller
`timescale 1ns/100ps
module usb_host_functional_state_ctrl_tb
  import ufs_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  localparam int FCNT = 16;
  localparam int SCNT = 20;
  logic        clock, nrst, wr, rd, wake;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, comm_base, s;
  logic        resume_in, resume_drive, owner_raw, owner_irq, sof_irq, resume_irq;
  logic [3:0]  other_raw, other_irq, list_en;
  logic        sof_token, rh_reset, irq;
  logic [1:0]  func_state;
  int          failures, samples_checked, cycles, n;

  ufs_ctrl #(.FRAME_CNT(FCNT), .SHORT_CNT(SCNT)) uut (
    .CLOCK(clock), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .RESUME_IN(resume_in), .RESUME_DRIVE(resume_drive),
    .OWNER_RAW(owner_raw), .OTHER_RAW(other_raw), .OWNER_IRQ(owner_irq),
    .SOF_IRQ(sof_irq), .RESUME_IRQ(resume_irq), .OTHER_IRQ(other_irq),
    .SOF_TOKEN(sof_token), .LIST_EN(list_en), .RH_RESET(rh_reset),
    .FUNC_STATE(func_state), .COMM_BASE(comm_base));

  ufs_dev_model dev (.clock(clock), .rh_reset(rh_reset), .wake(wake), .resume_in(resume_in));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic print_verdict();
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    cmp(rdata, exp);
  endtask

  task automatic irq_probe(input logic [3:0] exp_other);
    @(posedge clock);
    owner_raw <= 1'b1;
    other_raw <= 4'ha;
    @(posedge clock);
    owner_raw <= 1'b0;
    other_raw <= 4'h0;
    #1;
    cmp({31'h0, owner_irq}, 32'h1);
    cmp({28'h0, other_irq}, {28'h0, exp_other});
  endtask

  task automatic watch(input int k, output logic [31:0] seen);
    seen = '0;
    repeat (k) begin
      @(posedge clock);
      #1;
      seen = seen | {29'h0, sof_irq, sof_token, resume_irq};
    end
  endtask

  task automatic sof_look(input int lim, output int m, output logic hit);
    m   = -1;
    hit = 1'b0;
    for (int i = 0; i < lim && m < 0; i++) begin
      @(posedge clock);
      #1;
      if (sof_token === 1'b1) begin
        m   = i;
        hit = sof_irq;
      end
    end
  endtask

  task automatic pulse_wake();
    @(posedge clock);
    wake <= 1'b1;
    @(posedge clock);
    wake <= 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    cmp({30'h0, func_state}, {30'h0, ST_BUS_RESET});
    cmp({31'h0, rh_reset}, 32'h1);
    rd_chk(OFS_CONTROL, CONTROL_RST);
    rd_chk(8'h60, 32'h0);
    irq_probe(4'h0);
    $display("done: reset");
  endtask

  task automatic t_oper();
    wr_reg(OFS_COMM_PTR, 32'h1234_56ff);
    cmp(comm_base, 32'h1234_5600);
    wr_reg(8'h0c, 32'hcafe_0001);
    wr_reg(OFS_CONTROL, 32'h0000_01bc);
    cmp({30'h0, func_state}, {30'h0, ST_OPER});
    sof_look(FCNT + 1, n, irq);
    cmp({31'h0, n >= 0}, 32'h1);
    cmp({31'h0, irq}, 32'h1);
    cmp({28'h0, list_en}, 32'hf);
    cmp({31'h0, rh_reset}, 32'h0);
    sof_look(FCNT + 1, n, irq);
    cmp(n, FCNT - 1);
    irq_probe(4'ha);
    pulse_wake();
    watch(16, s);
    cmp(s & 32'h1, 32'h0);
    cmp({30'h0, func_state}, {30'h0, ST_OPER});
    rd_chk(OFS_CONTROL, 32'h0000_01bc);
    $display("done: operational");
  endtask

  task automatic t_bus_reset();
    wr_reg(OFS_CONTROL, 32'h0000_013c);
    step(1);
    cmp({31'h0, rh_reset}, 32'h1);
    irq_probe(4'h0);
    watch(2 * FCNT, s);
    cmp(s, 32'h0);
    rd_chk(8'h0c, 32'hcafe_0001);
    rd_chk(OFS_CONTROL, 32'h0000_013c);
    $display("done: bus reset");
  endtask

  task automatic t_suspend();
    wr_reg(OFS_CONTROL, 32'h0000_01fc);
    cmp({30'h0, func_state}, {30'h0, ST_SUSPEND});
    step(1);
    cmp({28'h0, list_en}, 32'h0);
    watch(2 * FCNT, s);
    cmp(s, 32'h0);
    irq_probe(4'h0);
    wr_reg(OFS_CONTROL, 32'h0000_01bc);
    cmp({30'h0, func_state}, {30'h0, ST_SUSPEND});
    rd_chk(8'h0c, 32'hcafe_0001);
    pulse_wake();
    for (int i = 0; i < 12 && func_state !== ST_RESUME; i++) step(1);
    cmp({30'h0, func_state}, {30'h0, ST_RESUME});
    cmp({31'h0, resume_irq}, 32'h1);
    $display("done: suspend");
  endtask

  task automatic t_resume();
    step(2);
    cmp({31'h0, resume_drive}, 32'h1);
    irq_probe(4'h0);
    watch(2 * FCNT, s);
    cmp(s, 32'h0);
    cmp({28'h0, list_en}, 32'h0);
    rd_chk(8'h0c, 32'hcafe_0001);
    wr_reg(OFS_CONTROL, 32'h0000_00bc);
    step(2);
    cmp({31'h0, resume_drive}, 32'h0);
    sof_look(FCNT + 1, n, irq);
    cmp({31'h0, n >= 0}, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    $display("done: resume");
  endtask

  task automatic t_short();
    wr_reg(OFS_COMMAND, 32'h0000_0001);
    cmp({30'h0, func_state}, {30'h0, ST_SUSPEND});
    wr_reg(OFS_CONTROL, 32'h0000_01bc);
    cmp({30'h0, func_state}, {30'h0, ST_OPER});
    wr_reg(OFS_COMMAND, 32'h0000_0001);
    step(SCNT + 2);
    wr_reg(OFS_CONTROL, 32'h0000_01bc);
    cmp({30'h0, func_state}, {30'h0, ST_SUSPEND});
    $display("done: short suspend");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    nrst      = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    wake      = 1'b0;
    addr      = 8'h00;
    wdata     = 32'h0;
    owner_raw = 1'b0;
    other_raw = 4'h0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    step(1);
    t_reset();
    t_oper();
    t_bus_reset();
    t_suspend();
    t_resume();
    t_short();
    print_verdict();
  end
endmodule
